/* core/cpsi_top.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Speed at 15:14, resets to 1000.
// - Duplex at bit 13, one is full.
// - Resolved bit 11; forced one without negotiation.
// - Page received bit 12 latches, clears on read.
// - Global link bit 3, real-time link bit 10.
// - Pause resolution mirrored in bits 9, 8.
// - Crossover bit 6, follows manual setting; in auto mode it shows the line result.
// - New crossover setting applies after soft reset.
// - Polarity bit 1, forced normal when disabled at speed 10.
// - Per-pair polarity shown in 1000 mode.
// - Enables gate the interrupt; kept across soft reset.
// - Enables 15..12: error, speed, duplex, page.
// - Enables 11..8: done, link, symbol, carrier.
// - Enables 6,5,4,3,1,0; bits 7, 2 reserved.
// - Downshift bit 5, energy detect bit 4.
// - Bits 7, 2 zero; jabber bit 0.
// - Event flags latch until read, written with one, or soft reset.
module cpsi_top
  import cpsi_pkg::*;
(
  // Clock and reset.
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // APB slave.
  input  wire cpsi_apb_req_t i_apb,
  output logic               o_pready,
  output logic [31:0]        o_prdata,
  output logic               o_pslverr,
  // Line-side status, asynchronous.
  input  wire cpsi_phy_t     i_phy,
  // Interrupt.
  output logic               o_irq
);

  cpsi_state_t q;
  cpsi_state_t d;

  // Word index of an address, and whether it hits a register.
  function automatic logic [5:0] idx_of(input logic [7:0] a);
    return a[7:2];
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic [5:0] i;
    i = idx_of(a);
    return (a[1:0] == 2'h0) &&
           (i == `CPSI_IDX_CTRL0 || i == `CPSI_IDX_CTRL1 ||
            i == `CPSI_IDX_STAT  || i == `CPSI_IDX_IEN ||
            i == `CPSI_IDX_EVT   || i == `CPSI_IDX_PAIRPOL);
  endfunction

  function automatic logic rose(input logic now, input logic was);
    return now & ~was;
  endfunction

  // Next-state logic for the whole block.
  always_comb begin
    cpsi_phy_t   s;
    cpsi_phy_t   p;
    logic        setup;
    logic        wr;
    logic        rd;
    logic [5:0]  ai;
    logic        resolved;
    logic        xo;
    logic        pol;
    logic        page;
    logic [15:0] stat;
    logic [15:0] ev_new;
    logic [15:0] clr;
    logic [15:0] rword;
    s        = q.sync2;
    p        = q.prev;
    d        = q;
    setup    = i_apb.psel & ~i_apb.penable;
    wr       = i_apb.psel & i_apb.penable & q.pready & i_apb.pwrite & ~q.pslverr;
    rd       = i_apb.psel & i_apb.penable & q.pready & ~i_apb.pwrite & ~q.pslverr;
    ai       = idx_of(i_apb.paddr);
    resolved = q.an_en ? s.an_done : 1'b1;
    pol      = (q.pol_dis && s.speed == `CPSI_SPD_10) ? 1'b0 : s.pol;
    clr      = 16'h0000;
    rword    = 16'h0000;
    xo       = 1'b0;
    page     = 1'b0;
    stat     = 16'h0000;
    ev_new   = 16'h0000;

    // Only the first synchroniser stage reads the pins.
    d.sync1 = i_phy;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;

    // Manual crossover shows the applied setting, auto shows the line.
    unique case (q.xo_app)
      CPSI_XO_MDI:  xo = 1'b0;
      CPSI_XO_MDIX: xo = 1'b1;
      default:      xo = s.mdix_auto;
    endcase

    // Clear-on-read only drops the bits that were actually returned, so a
    // flag set between the setup and access edges is never lost.
    if (rd && ai == `CPSI_IDX_STAT) begin
      clr[`CPSI_B_PAGE] = q.prdata[`CPSI_B_PAGE];
    end
    page = (q.stat[`CPSI_B_PAGE] & ~clr[`CPSI_B_PAGE]) | rose(s.page_rx, p.page_rx);

    stat = {s.speed, s.duplex, page, resolved, s.link_rt,
            s.pause_tx, s.pause_rx, 1'b0, xo,
            s.downshift, s.edet_sleep, s.link_up, 1'b0, pol, s.jabber};

    // Events, one per enable bit.
    ev_new = {rose(s.an_err, p.an_err),
              s.speed != p.speed,
              s.duplex != p.duplex,
              rose(s.page_rx, p.page_rx),
              rose(s.an_done, p.an_done),
              s.link_up != p.link_up,
              rose(s.sym_err, p.sym_err),
              rose(s.false_car, p.false_car),
              1'b0,
              xo != q.stat[6],
              rose(s.downshift, p.downshift),
              s.edet_sleep != p.edet_sleep,
              rose(s.flp_nolink, p.flp_nolink),
              1'b0,
              pol != q.stat[1],
              rose(s.jabber, p.jabber)};

    // Reading the event register or writing ones to it clears flags.
    if (rd && ai == `CPSI_IDX_EVT) begin
      clr = q.prdata[15:0];
    end else if (wr && ai == `CPSI_IDX_EVT) begin
      clr = i_apb.pwdata[15:0];
    end
    d.ev   = ((q.ev & ~clr) | ev_new) & `CPSI_RSVD_MASK;
    d.stat = stat;
    d.sr   = 1'b0;

    // Register writes take effect at the access edge.
    if (wr) begin
      unique case (ai)
        `CPSI_IDX_CTRL0: begin
          d.sr    = i_apb.pwdata[`CPSI_B_SRST];
          d.an_en = i_apb.pwdata[`CPSI_B_ANEN];
        end
        `CPSI_IDX_CTRL1: begin
          d.xo_mode = cpsi_xo_t'(i_apb.pwdata[`CPSI_B_XO_HI:`CPSI_B_XO_LO]);
          d.pol_dis = i_apb.pwdata[`CPSI_B_POLDIS];
        end
        `CPSI_IDX_IEN: d.en = i_apb.pwdata[15:0] & `CPSI_RSVD_MASK;
        default: ;
      endcase
    end

    // Soft reset clears the fields that it owns; enables are untouched.
    if (q.sr) begin
      d.xo_app = q.xo_mode;
      d.stat   = stat & `CPSI_STAT_KEEP;
      d.ev     = 16'h0000;
    end

    // Read data and error are prepared in setup; one wait-free access.
    d.pready = setup;
    if (setup) begin
      d.pslverr = ~is_mapped(i_apb.paddr);
      unique case (ai)
        `CPSI_IDX_CTRL0:   rword = 16'(q.an_en) << `CPSI_B_ANEN;
        `CPSI_IDX_CTRL1:   rword = (16'(q.xo_mode) << `CPSI_B_XO_LO) |
                                   (16'(q.pol_dis) << `CPSI_B_POLDIS);
        `CPSI_IDX_STAT:    rword = q.stat;
        `CPSI_IDX_IEN:     rword = q.en;
        `CPSI_IDX_EVT:     rword = q.ev;
        `CPSI_IDX_PAIRPOL: rword = (s.speed == `CPSI_SPD_1000) ? 16'(s.pair_pol) : 16'h0000;
        default:           rword = 16'h0000;
      endcase
      d.prdata = {16'h0000, rword};
    end

    d.irq = |(d.ev & d.en);
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q <= CPSI_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Every output comes straight from the state register.
  assign o_pready  = q.pready;
  assign o_prdata  = q.prdata;
  assign o_pslverr = q.pslverr;
  assign o_irq     = q.irq;

  // Access-phase decodes used by the checks below.
  logic acc_rd;
  logic acc_wr;
  assign acc_rd = i_apb.psel & i_apb.penable & q.pready & ~i_apb.pwrite & ~q.pslverr;
  assign acc_wr = i_apb.psel & i_apb.penable & q.pready & i_apb.pwrite & ~q.pslverr;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  speed_reset_a: assert property ($rose(i_rst_b) |-> q.stat[15:14] == `CPSI_SPD_1000)
    else $error("speed field not at reset value");

  resolved_forced_a: assert property (
    !q.an_en && !q.sr |=> q.stat[`CPSI_B_RESOLV])
    else $error("resolved bit not forced with negotiation off");

  page_latch_a: assert property (
    rose(q.sync2.page_rx, q.prev.page_rx) && !q.sr |=> q.stat[`CPSI_B_PAGE] [*2])
    else $error("page received not latched");

  reserved_zero_a: assert property (q.stat[7] == 1'b0 && q.stat[2] == 1'b0 &&
    q.en[7] == 1'b0 && q.en[2] == 1'b0)
    else $error("reserved bit set");

  xo_hold_a: assert property (!q.sr |=> $stable(q.xo_app))
    else $error("crossover applied without soft reset");

  xo_manual_a: assert property (
    q.xo_app == CPSI_XO_MDI && !q.sr |=> !q.stat[6])
    else $error("manual crossover not shown");

  pol_forced_a: assert property (
    q.pol_dis && q.sync2.speed == `CPSI_SPD_10 && !q.sr |=> !q.stat[1])
    else $error("polarity not forced normal");

  enable_keep_a: assert property (q.sr |=> q.en == $past(q.en))
    else $error("enables changed by soft reset");

  irq_level_a: assert property (
    q.en[0] && rose(q.sync2.jabber, q.prev.jabber) && !q.sr && !acc_wr |=> o_irq)
    else $error("enabled event did not raise the interrupt");

  event_hold_a: assert property (
    q.ev[15] && !q.sr && !(o_pready && i_apb.psel && i_apb.penable) |=> q.ev[15])
    else $error("event flag lost without read");

  // Status fields track the synchronised line one edge later, outside soft reset.
  speed_follow_a: assert property (
    !q.sr |=> q.stat[15:14] == $past(q.sync2.speed))
    else $error("speed field does not follow the line");

  duplex_follow_a: assert property (
    !q.sr |=> q.stat[13] == $past(q.sync2.duplex))
    else $error("duplex bit does not follow the line");

  resolved_follow_a: assert property (
    q.an_en && !q.sr |=> q.stat[`CPSI_B_RESOLV] == $past(q.sync2.an_done))
    else $error("resolved bit does not follow negotiation");

  link_follow_a: assert property (
    !q.sr |=> q.stat[10] == $past(q.sync2.link_rt) && q.stat[3] == $past(q.sync2.link_up))
    else $error("link bits do not follow the line");

  pause_follow_a: assert property (
    !q.sr |=> q.stat[9] == $past(q.sync2.pause_tx) && q.stat[8] == $past(q.sync2.pause_rx))
    else $error("pause bits do not follow the line");

  xo_mdix_a: assert property (
    q.xo_app == CPSI_XO_MDIX |=> q.stat[6])
    else $error("manual crossover to mdix not shown");

  xo_auto_a: assert property (
    q.xo_app == CPSI_XO_AUTO |=> q.stat[6] == $past(q.sync2.mdix_auto))
    else $error("automatic crossover result not shown");

  xo_apply_a: assert property (
    q.sr |=> q.xo_app == $past(q.xo_mode))
    else $error("soft reset did not apply crossover setting");

  pol_follow_a: assert property (
    !q.pol_dis && !q.sr |=> q.stat[1] == $past(q.sync2.pol))
    else $error("polarity bit does not follow the line");

  jabber_follow_a: assert property (
    !q.sr |=> q.stat[0] == $past(q.sync2.jabber))
    else $error("jabber bit does not follow the line");

  downshift_follow_a: assert property (
    !q.sr |=> q.stat[5] == $past(q.sync2.downshift) && q.stat[4] == $past(q.sync2.edet_sleep))
    else $error("downshift or energy bit does not follow the line");

  // The page flag drops only on soft reset or when a status read has returned it.
  page_clear_a: assert property (
    acc_rd && i_apb.paddr == {`CPSI_IDX_STAT, 2'h0} && q.prdata[`CPSI_B_PAGE] &&
    !rose(q.sync2.page_rx, q.prev.page_rx) |=> !q.stat[`CPSI_B_PAGE])
    else $error("page received not cleared by read");

  page_hold_a: assert property (
    q.stat[`CPSI_B_PAGE] && !q.sr && !acc_rd |=> q.stat[`CPSI_B_PAGE])
    else $error("page received lost without read");

  // Per-pair polarity is returned only at gigabit speed.
  pairs_shown_a: assert property (
    i_apb.psel && !i_apb.penable && i_apb.paddr == {`CPSI_IDX_PAIRPOL, 2'h0} &&
    q.sync2.speed == `CPSI_SPD_1000 |=> o_prdata[3:0] == $past(q.sync2.pair_pol))
    else $error("pair polarity not returned at gigabit");

  pairs_hidden_a: assert property (
    i_apb.psel && !i_apb.penable && i_apb.paddr == {`CPSI_IDX_PAIRPOL, 2'h0} &&
    q.sync2.speed != `CPSI_SPD_1000 |=> o_prdata == 32'h0000_0000)
    else $error("pair polarity returned below gigabit");

  // Enables change only by a write, and with none set the interrupt stays low.
  enable_stable_a: assert property (
    !(acc_wr && i_apb.paddr == {`CPSI_IDX_IEN, 2'h0}) |=> $stable(q.en))
    else $error("enable bits changed without a write");

  irq_masked_a: assert property (
    q.en == 16'h0000 && !acc_wr |=> !o_irq)
    else $error("interrupt raised with all enables clear");

  // Every line event outside soft reset lands in its own flag on the next edge.
  event_rsvd_a: assert property (q.ev[7] == 1'b0 && q.ev[2] == 1'b0)
    else $error("reserved event flag set");

  sr_clear_a: assert property (
    q.sr |=> q.ev == 16'h0000)
    else $error("soft reset did not clear event flags");

  an_err_event_a: assert property (
    rose(q.sync2.an_err, q.prev.an_err) && !q.sr |=> q.ev[15])
    else $error("negotiation error not flagged");

  speed_event_a: assert property (
    q.sync2.speed != q.prev.speed && !q.sr |=> q.ev[14])
    else $error("speed change not flagged");

  duplex_event_a: assert property (
    q.sync2.duplex != q.prev.duplex && !q.sr |=> q.ev[13])
    else $error("duplex change not flagged");

  page_event_a: assert property (
    rose(q.sync2.page_rx, q.prev.page_rx) && !q.sr |=> q.ev[12])
    else $error("page received not flagged");

  done_event_a: assert property (
    rose(q.sync2.an_done, q.prev.an_done) && !q.sr |=> q.ev[11])
    else $error("negotiation done not flagged");

  link_event_a: assert property (
    q.sync2.link_up != q.prev.link_up && !q.sr |=> q.ev[10])
    else $error("link change not flagged");

  symbol_event_a: assert property (
    rose(q.sync2.sym_err, q.prev.sym_err) && !q.sr |=> q.ev[9])
    else $error("symbol error not flagged");

  carrier_event_a: assert property (
    rose(q.sync2.false_car, q.prev.false_car) && !q.sr |=> q.ev[8])
    else $error("false carrier not flagged");

  downshift_event_a: assert property (
    rose(q.sync2.downshift, q.prev.downshift) && !q.sr |=> q.ev[5])
    else $error("downshift not flagged");

  energy_event_a: assert property (
    q.sync2.edet_sleep != q.prev.edet_sleep && !q.sr |=> q.ev[4])
    else $error("energy detect change not flagged");

  flp_event_a: assert property (
    rose(q.sync2.flp_nolink, q.prev.flp_nolink) && !q.sr |=> q.ev[3])
    else $error("exchange without link not flagged");

  jabber_event_a: assert property (
    rose(q.sync2.jabber, q.prev.jabber) && !q.sr |=> q.ev[0])
    else $error("jabber not flagged");

endmodule

/* pkg/cpsi_defs.svh */
`ifndef CPSI_DEFS_SVH
`define CPSI_DEFS_SVH

// Register indices; the byte address is four times the index.
`define CPSI_IDX_CTRL0   6'h00
`define CPSI_IDX_CTRL1   6'h10
`define CPSI_IDX_STAT    6'h11
`define CPSI_IDX_IEN     6'h12
`define CPSI_IDX_EVT     6'h13
`define CPSI_IDX_PAIRPOL 6'h1c

// Field positions.
`define CPSI_B_SRST    15
`define CPSI_B_ANEN    12
`define CPSI_B_POLDIS  1
`define CPSI_B_XO_HI   6
`define CPSI_B_XO_LO   5
`define CPSI_B_PAGE    12
`define CPSI_B_RESOLV  11

// Speed codes.
`define CPSI_SPD_10    2'h0
`define CPSI_SPD_1000  2'h2

// Reset values and masks.
`define CPSI_STAT_RST  16'h8040
`define CPSI_STAT_KEEP 16'he040
`define CPSI_RSVD_MASK 16'hff7b
`define CPSI_IEN_RST   16'h0000
`define CPSI_ANEN_RST  1'h1

`endif

/* pkg/cpsi_pkg.sv */
package cpsi_pkg;
  `include "cpsi_defs.svh"

  // Crossover configuration codes.
  typedef enum logic [1:0] {
    CPSI_XO_MDI  = 2'h0,
    CPSI_XO_MDIX = 2'h1,
    CPSI_XO_RSVD = 2'h2,
    CPSI_XO_AUTO = 2'h3
  } cpsi_xo_t;

  // Line-side status levels from the analog front end.
  typedef struct packed {
    logic [1:0] speed;
    logic       duplex;
    logic       an_done;
    logic       page_rx;
    logic       link_rt;
    logic       link_up;
    logic       pause_tx;
    logic       pause_rx;
    logic       mdix_auto;
    logic       downshift;
    logic       edet_sleep;
    logic       pol;
    logic       jabber;
    logic [3:0] pair_pol;
    logic       an_err;
    logic       sym_err;
    logic       false_car;
    logic       flp_nolink;
  } cpsi_phy_t;

  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cpsi_apb_req_t;

  // Whole block state.
  typedef struct packed {
    cpsi_phy_t   sync1;
    cpsi_phy_t   sync2;
    cpsi_phy_t   prev;
    logic [15:0] stat;
    logic [15:0] ev;
    logic [15:0] en;
    logic        an_en;
    logic        pol_dis;
    cpsi_xo_t    xo_mode;
    cpsi_xo_t    xo_app;
    logic        sr;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } cpsi_state_t;

  localparam cpsi_state_t CPSI_STATE_RST = '{
    sync1: '0, sync2: '0, prev: '0,
    stat: `CPSI_STAT_RST, ev: 16'h0000, en: `CPSI_IEN_RST,
    an_en: `CPSI_ANEN_RST, pol_dis: 1'h0,
    xo_mode: CPSI_XO_AUTO, xo_app: CPSI_XO_AUTO,
    sr: 1'h0, prdata: 32'h0000_0000, pready: 1'h0,
    pslverr: 1'h0, irq: 1'h0
  };
endpackage

/* verification/cpsi_top_bench.sv */
`timescale 1ns/1ps
`include "cpsi_defs.svh"
module cpsi_top_bench
  import cpsi_pkg::*;
;
  // Stimulus, observed outputs and counters.
  logic          i_clk = 1'h0;
  logic          i_rst_b = 1'h0;
  cpsi_apb_req_t apb = '0;
  cpsi_phy_t     phy = '{speed: 2'h2, mdix_auto: 1'h1, default: '0};
  cpsi_phy_t     cur;
  logic          o_pready;
  logic [31:0]   o_prdata;
  logic          o_pslverr;
  logic          o_irq;
  logic [31:0]   rd;
  logic          err;
  logic [15:0]   ien = 16'h7f7b;
  logic [15:0]   evbit [13] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400,
                                16'h0200, 16'h0100, 16'h0020, 16'h0010, 16'h0008, 16'h0002,
                                16'h0001};
  int            fails = 0;
  int            tests_run = 0;

  // Free-running 25 MHz clock.
  always #20 i_clk = ~i_clk;

  cpsi_top dut_u (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_apb     (apb),
    .o_pready  (o_pready),
    .o_prdata  (o_prdata),
    .o_pslverr (o_pslverr),
    .i_phy     (phy),
    .o_irq     (o_irq)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request stands until pready is seen, so answers within 20 edges are fine.
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    apb <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: {idx, 2'h0},
             pwdata: {16'h0000, wd}};
    @(posedge i_clk);
    apb.penable <= 1'h1;
    // Pready, read data and error are all taken at the same rising edge.
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'h1 && n < 20);
    if (o_pready !== 1'h1) begin
      fails++;
      summarize();
    end
    rd = o_prdata;
    err = o_pslverr;
    apb.psel <= 1'h0;
    apb.penable <= 1'h0;
  endtask

  task automatic rdchk(input string what, input logic [5:0] idx, input logic [15:0] exp);
    xfer(1'h0, idx, 16'h0000);
    chk(what, rd, {16'h0000, exp});
  endtask

  // Applies the line state and lets it cross the synchronisers.
  task automatic put(input cpsi_phy_t p);
    @(posedge i_clk);
    phy <= p;
    cur = p;
    repeat (5) @(posedge i_clk);
  endtask

  // Interrupt follows enabled flags; reading the flags clears them and the interrupt.
  task automatic ev(input logic [15:0] exp);
    @(negedge i_clk);
    chk("irq", {31'h0, o_irq}, {31'h0, |(exp & ien)});
    rdchk("events", `CPSI_IDX_EVT, exp);
    repeat (2) @(negedge i_clk);
    chk("irq cleared", {31'h0, o_irq}, 32'h0);
  endtask

  // Main sequence.
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'h1;
    put(phy);
    rdchk("status rst", `CPSI_IDX_STAT, 16'h8040);
    rdchk("ien rst", `CPSI_IDX_IEN, 16'h0000);
    xfer(1'h0, 6'h05, 16'h0000);
    chk("unmapped err", {31'h0, err}, 32'h1);
    put('{speed: 2'h1, duplex: 1'h1, an_done: 1'h1, link_rt: 1'h1, link_up: 1'h1,
          pause_tx: 1'h1, mdix_auto: 1'h1, downshift: 1'h1, pol: 1'h1, jabber: 1'h1,
          default: '0});
    rdchk("status a", `CPSI_IDX_STAT, 16'h6e6b);
    put('{pause_rx: 1'h1, edet_sleep: 1'h1, pol: 1'h1, default: '0});
    rdchk("status b", `CPSI_IDX_STAT, 16'h0112);
    xfer(1'h1, `CPSI_IDX_CTRL1, 16'h0062);
    rdchk("pol forced", `CPSI_IDX_STAT, 16'h0110);
    xfer(1'h1, `CPSI_IDX_CTRL1, 16'h0060);
    xfer(1'h1, `CPSI_IDX_CTRL0, 16'h0000);
    rdchk("resolved no an", `CPSI_IDX_STAT, 16'h0912);
    xfer(1'h1, `CPSI_IDX_CTRL0, 16'h1000);
    cur.page_rx = 1'h1;
    put(cur);
    rdchk("page set", `CPSI_IDX_STAT, 16'h1112);
    rdchk("page clear", `CPSI_IDX_STAT, 16'h0112);
    xfer(1'h1, `CPSI_IDX_IEN, 16'hffff);
    xfer(1'h1, `CPSI_IDX_CTRL1, 16'h0020);
    rdchk("xo pending", `CPSI_IDX_STAT, 16'h0112);
    xfer(1'h1, `CPSI_IDX_CTRL0, 16'h9000);
    repeat (2) @(posedge i_clk); // Status reads cleared fields for one cycle after soft reset.
    rdchk("xo mdix", `CPSI_IDX_STAT, 16'h0152);
    rdchk("ien kept", `CPSI_IDX_IEN, 16'hff7b);
    xfer(1'h1, `CPSI_IDX_CTRL1, 16'h0000);
    xfer(1'h1, `CPSI_IDX_CTRL0, 16'h9000);
    repeat (2) @(posedge i_clk); // Let the soft reset cycle pass before reading.
    rdchk("xo mdi", `CPSI_IDX_STAT, 16'h0112);
    cur.speed = 2'h2;
    cur.pair_pol = 4'ha;
    put(cur);
    rdchk("pairs 1000", `CPSI_IDX_PAIRPOL, 16'h000a);
    cur.speed = 2'h0;
    cur.page_rx = 1'h0;
    put(cur);
    rdchk("pairs 10", `CPSI_IDX_PAIRPOL, 16'h0000);
    xfer(1'h1, `CPSI_IDX_IEN, ien);
    xfer(1'h0, `CPSI_IDX_EVT, 16'h0000);
    // One event at a time; the first one is masked.
    for (int k = 0; k < 13; k++) begin
      case (k)
        0: cur.an_err = 1'h1;
        1: cur.speed = 2'h1;
        2: cur.duplex = 1'h1;
        3: cur.page_rx = 1'h1;
        4: cur.an_done = 1'h1;
        5: cur.link_up = 1'h1;
        6: cur.sym_err = 1'h1;
        7: cur.false_car = 1'h1;
        8: cur.downshift = 1'h1;
        9: cur.edet_sleep = 1'h0;
        10: cur.flp_nolink = 1'h1;
        11: cur.pol = 1'h0;
        default: cur.jabber = 1'h1;
      endcase
      put(cur);
      ev(evbit[k]);
    end
    cur.sym_err = 1'h0;
    put(cur);
    cur.sym_err = 1'h1;
    put(cur);
    xfer(1'h1, `CPSI_IDX_EVT, 16'h0200);
    ev(16'h0000);
    summarize();
  end
endmodule
